// File: rtl/bfo_core.sv
`timescale 1ns/1ns
// What this block does
// - A test-skip-if-zero instruction skips the next instruction when the selected file bit reads zero.
// - The next program word is fetched while the current instruction executes.
// - A taken skip drops the prefetched word and runs a no-operation with no side effects instead.
// - A test-skip-if-zero whose skip is taken occupies two instruction cycles, the second a no-operation.
// - A test-skip-if-zero on a bit that is one takes one cycle and the prefetched instruction runs next.
// - Bit instructions carry a 7-bit file address (0 to 127) and a 3-bit bit position (0 to 7).
module bfo_core (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Program memory
  output logic [bfo_pkg::PC_W-1:0] prog_addr,
  input wire logic [bfo_pkg::WORD_W-1:0] prog_word,
  // File register read
  output logic [bfo_pkg::ADDR_W-1:0] fr_raddr,
  input wire logic [bfo_pkg::DATA_W-1:0] fr_rdata,
  // File register write
  output logic fr_we,
  output logic [bfo_pkg::ADDR_W-1:0] fr_waddr,
  output logic [bfo_pkg::DATA_W-1:0] fr_wdata,
  // Hand-off of other instructions
  output logic other_valid,
  output logic [bfo_pkg::WORD_W-1:0] other_word,
  // Status
  output logic skip_taken,
  output logic nop_exec
);

  typedef struct packed {
    logic [bfo_pkg::PC_W-1:0] pc;
    logic [bfo_pkg::WORD_W-1:0] pre;
    logic pre_v;
    logic squash;
    logic we;
    logic [bfo_pkg::ADDR_W-1:0] waddr;
    logic [bfo_pkg::DATA_W-1:0] wdata;
    logic skip;
    logic nop;
  } bfo_state_t;

  bfo_state_t st_q;
  bfo_state_t st_d;

  logic exec_v;
  logic [bfo_pkg::DATA_W-1:0] eff_rdata;
  logic [bfo_pkg::DATA_W-1:0] bit_mask;
  logic [bfo_pkg::DATA_W-1:0] clr_val;
  logic [bfo_pkg::DATA_W-1:0] set_val;
  logic bit_val;
  logic is_clr;
  logic is_set;
  logic is_tst;

  bfo_dec_if dif ();

  bfo_decode i_bfo_decode (
    .d(dif)
  );

  // ------------------------------------------------------------------
  // Execute stage
  // ------------------------------------------------------------------
  // A squashed slot never reaches the decoder as a live word
  assign exec_v = st_q.pre_v & ~st_q.squash;
  assign dif.word = st_q.pre;
  assign dif.valid = exec_v;

  assign is_clr = dif.op == bfo_pkg::BFO_OP_BIT_CLEAR;
  assign is_set = dif.op == bfo_pkg::BFO_OP_BIT_SET;
  assign is_tst = dif.op == bfo_pkg::BFO_OP_TEST_ZERO;

  // Forward the pending write; the file sees it one cycle late
  assign eff_rdata = (st_q.we && st_q.waddr == dif.addr) ? st_q.wdata : fr_rdata;
  assign bit_mask = bfo_pkg::BIT_ONE << dif.bitpos;
  assign bit_val = |(eff_rdata & bit_mask);
  assign clr_val = eff_rdata & ~bit_mask;
  assign set_val = eff_rdata | bit_mask;

  always_comb begin
    st_d = st_q;
    // Prefetch runs every cycle, even under a skip
    st_d.pc = st_q.pc + 13'h0001;
    st_d.pre = prog_word;
    st_d.pre_v = 1'b1;
    st_d.squash = 1'b0;
    st_d.we = 1'b0;
    st_d.skip = 1'b0;
    // Nop flag rides with the skip, so both mark the dropped slot
    st_d.nop = 1'b0;
    if (is_clr) begin
      st_d.we = 1'b1;
      st_d.waddr = dif.addr;
      st_d.wdata = clr_val;
    end else if (is_set) begin
      st_d.we = 1'b1;
      st_d.waddr = dif.addr;
      st_d.wdata = set_val;
    end else if (is_tst && !bit_val) begin
      st_d.squash = 1'b1;
      st_d.skip = 1'b1;
      st_d.nop = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{pc: bfo_pkg::RESET_PC, pre: bfo_pkg::RESET_WORD, waddr: '0, wdata: '0, default: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign prog_addr = st_q.pc;
  assign fr_raddr = dif.addr;
  assign fr_we = st_q.we;
  assign fr_waddr = st_q.waddr;
  assign fr_wdata = st_q.wdata;
  assign other_valid = dif.op == bfo_pkg::BFO_OP_OTHER;
  assign other_word = st_q.pre;
  assign skip_taken = st_q.skip;
  assign nop_exec = st_q.nop;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // Steps of a taken skip: the test, then the dropped slot
  sequence s_test_zero;
    exec_v && is_tst && !bit_val;
  endsequence

  sequence s_nop_slot;
    !exec_v && nop_exec && !other_valid && !fr_we;
  endsequence

  property p_skip_on_zero;
    s_test_zero |=> skip_taken && !fr_we;
  endproperty
  a_skip_on_zero: assert property (p_skip_on_zero) else $error("zero bit did not skip");

  property p_prefetch;
    // Starts only once nrst is sampled high, so the release edge is not judged
    nrst |=> st_q.pre == $past(prog_word) && prog_addr == $past(prog_addr) + 13'h0001;
  endproperty
  a_prefetch: assert property (p_prefetch) else $error("prefetch did not advance");

  property p_drop_word;
    s_test_zero |=> s_nop_slot ##1 !fr_we && !skip_taken;
  endproperty
  a_drop_word: assert property (p_drop_word) else $error("dropped word had an effect");

  property p_two_cycles;
    s_test_zero |=> !exec_v ##1 exec_v && !nop_exec;
  endproperty
  a_two_cycles: assert property (p_two_cycles) else $error("taken skip not two cycles");

  property p_no_skip_on_one;
    exec_v && is_tst && bit_val |=> exec_v && !skip_taken && !nop_exec;
  endproperty
  a_no_skip_on_one: assert property (p_no_skip_on_one) else $error("set bit skipped");

  property p_addr_field;
    exec_v && (is_clr || is_set) |=> fr_we && fr_waddr == $past(fr_raddr);
  endproperty
  a_addr_field: assert property (p_addr_field) else $error("write address wrong");

  property p_clear_value;
    exec_v && is_clr |=> fr_wdata == $past(clr_val) && !skip_taken;
  endproperty
  a_clear_value: assert property (p_clear_value) else $error("clear wrote wrong value");

  property p_set_value;
    exec_v && is_set |=> fr_wdata == $past(set_val) && !skip_taken;
  endproperty
  a_set_value: assert property (p_set_value) else $error("set wrote wrong value");

  property p_decode;
    exec_v && st_q.pre[13:10] == 4'h6 |-> is_tst && !other_valid;
  endproperty
  a_decode: assert property (p_decode) else $error("test word misdecoded");

  // ------------------------------------------------------------------
  // Slot timing, side-effect and forwarding checks
  // ------------------------------------------------------------------
  property p_skip_one_pulse;
    skip_taken |=> !skip_taken;
  endproperty
  a_skip_one_pulse: assert property (p_skip_one_pulse) else $error("skip pulse too long");

  property p_nop_one_slot;
    nop_exec |=> !nop_exec && exec_v;
  endproperty
  a_nop_one_slot: assert property (p_nop_one_slot) else $error("nop slot too long");

  property p_bit_op_one_cycle;
    exec_v && (is_clr || is_set) |=> exec_v && !nop_exec;
  endproperty
  a_bit_op_one_cycle: assert property (p_bit_op_one_cycle) else $error("bit op took two cycles");

  property p_test_no_write;
    exec_v && is_tst |=> !fr_we;
  endproperty
  a_test_no_write: assert property (p_test_no_write) else $error("test wrote the file");

  property p_other_clean;
    other_valid |=> !fr_we && !skip_taken && !nop_exec;
  endproperty
  a_other_clean: assert property (p_other_clean) else $error("handed-off word acted here");

  // Back-to-back set on the address just written must see the pending data
  property p_forward_set;
    exec_v && is_set && fr_we && fr_waddr == fr_raddr |=> fr_wdata == ($past(fr_wdata) | $past(bit_mask));
  endproperty
  a_forward_set: assert property (p_forward_set) else $error("pending write not forwarded");

endmodule : bfo_core

// File: rtl/bfo_dec_if.sv
`timescale 1ns/1ns
interface bfo_dec_if;
  logic [bfo_pkg::WORD_W-1:0] word;
  logic valid;
  bfo_pkg::bfo_op_t op;
  logic [bfo_pkg::ADDR_W-1:0] addr;
  logic [bfo_pkg::BIT_W-1:0] bitpos;

  modport core (output word, output valid, input op, input addr, input bitpos);
  modport dec (input word, input valid, output op, output addr, output bitpos);
endinterface : bfo_dec_if

// File: rtl/bfo_decode.sv
`timescale 1ns/1ns
module bfo_decode (
  // Decode path
  bfo_dec_if.dec d
);

  always_comb begin
    d.addr = d.word[bfo_pkg::ADDR_MSB:bfo_pkg::ADDR_LSB];
    d.bitpos = d.word[bfo_pkg::BITPOS_MSB:bfo_pkg::BITPOS_LSB];
    d.op = bfo_pkg::BFO_OP_OTHER;
    if (!d.valid) begin
      d.op = bfo_pkg::BFO_OP_NONE;
    end else if (d.word[bfo_pkg::CLASS_MSB:bfo_pkg::CLASS_LSB] == bfo_pkg::CLASS_BITOP) begin
      // Skip-if-set falls to the default and is handed off as an other instruction
      unique case (d.word[bfo_pkg::SUB_MSB:bfo_pkg::SUB_LSB])
        bfo_pkg::SUB_CLEAR: d.op = bfo_pkg::BFO_OP_BIT_CLEAR;
        bfo_pkg::SUB_SET: d.op = bfo_pkg::BFO_OP_BIT_SET;
        bfo_pkg::SUB_TEST_ZERO: d.op = bfo_pkg::BFO_OP_TEST_ZERO;
        default: d.op = bfo_pkg::BFO_OP_OTHER;
      endcase
    end
  end

endmodule : bfo_decode

// File: rtl/bfo_pkg.sv
package bfo_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W = 14;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned BIT_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W = 13;

  // ----------------------------------------------------------------
  // Instruction word fields
  // ----------------------------------------------------------------
  localparam int unsigned CLASS_MSB = 13;
  localparam int unsigned CLASS_LSB = 12;
  localparam int unsigned SUB_MSB = 11;
  localparam int unsigned SUB_LSB = 10;
  localparam int unsigned BITPOS_MSB = 9;
  localparam int unsigned BITPOS_LSB = 7;
  localparam int unsigned ADDR_MSB = 6;
  localparam int unsigned ADDR_LSB = 0;

  localparam logic [1:0] CLASS_BITOP = 2'h1;
  localparam logic [1:0] SUB_CLEAR = 2'h0;
  localparam logic [1:0] SUB_SET = 2'h1;
  localparam logic [1:0] SUB_TEST_ZERO = 2'h2;

  // ----------------------------------------------------------------
  // Reset values and the bit mask base
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] RESET_PC = 13'h0000;
  localparam logic [WORD_W-1:0] RESET_WORD = 14'h0000;
  localparam logic [DATA_W-1:0] BIT_ONE = 8'h01;

  typedef enum logic [2:0] {
    BFO_OP_NONE,
    BFO_OP_BIT_CLEAR,
    BFO_OP_BIT_SET,
    BFO_OP_TEST_ZERO,
    BFO_OP_OTHER
  } bfo_op_t;

endpackage : bfo_pkg

// File: testbench/bit_oriented_file_ops_tb.sv
`timescale 1ns/1ns
module bit_oriented_file_ops_tb;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [13:0] prog_word = 14'h0000;
  logic [7:0] fr_rdata = 8'h00;
  logic [12:0] prog_addr;
  logic [6:0] fr_raddr;
  logic [6:0] fr_waddr;
  logic [7:0] fr_wdata;
  logic [13:0] other_word;
  logic fr_we;
  logic other_valid;
  logic skip_taken;
  logic nop_exec;
  logic [13:0] mem [64];
  logic [7:0] file [128];
  logic [14:0] wr_q [$];
  logic [13:0] oth_q [$];
  int skips;
  int nops;
  int miscompares = 0;
  int tests_run = 0;

  always #20 ref_clk = ~ref_clk;

  bfo_core i_bfo_core (.ref_clk(ref_clk), .nrst(nrst), .prog_addr(prog_addr), .prog_word(prog_word),
    .fr_raddr(fr_raddr), .fr_rdata(fr_rdata), .fr_we(fr_we), .fr_waddr(fr_waddr), .fr_wdata(fr_wdata),
    .other_valid(other_valid), .other_word(other_word), .skip_taken(skip_taken), .nop_exec(nop_exec));

  // ----------------------------------------
  // Program memory and file models
  // ----------------------------------------
  // Registered one edge ahead, so the read looks combinational to the core
  always @(posedge ref_clk) begin
    prog_word <= nrst ? mem[6'(prog_addr + 13'h1)] : mem[0];
    fr_rdata <= (fr_we && fr_waddr == prog_word[6:0]) ? fr_wdata : file[prog_word[6:0]];
    if (fr_we) file[fr_waddr] <= fr_wdata;
    if (nrst) begin
      if (fr_we === 1'b1) wr_q.push_back({fr_waddr, fr_wdata});
      if (other_valid === 1'b1) oth_q.push_back(other_word);
      if (skip_taken === 1'b1) skips++;
      if (nop_exec === 1'b1) nops++;
    end
  end

  function automatic logic [13:0] enc(input logic [1:0] sub, input logic [2:0] b, input logic [6:0] f);
    return {2'h1, sub, b, f};
  endfunction : enc

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic hold();
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    foreach (mem[i]) mem[i] = 14'h0000;
    foreach (file[i]) file[i] = 8'h00;
    wr_q.delete();
    oth_q.delete();
    skips = 0;
    nops = 0;
  endtask : hold

  task automatic go(input int n);
    @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : go

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Back to back read-modify-write on one address needs forwarding
  task automatic t_clear_set();
    hold();
    mem[0] = enc(2'h0, 3'h7, 7'h05);
    mem[1] = enc(2'h1, 3'h3, 7'h05);
    mem[2] = enc(2'h1, 3'h0, 7'h7f);
    mem[3] = enc(2'h0, 3'h0, 7'h00);
    file[5] = 8'hc7;
    file[0] = 8'hff;
    go(10);
    chk("write count", 16'h0004, 16'(wr_q.size()));
    if (wr_q.size() == 4) begin
      chk("clear bit 7", {1'b0, 7'h05, 8'h47}, {1'b0, wr_q[0]});
      chk("set after clear", {1'b0, 7'h05, 8'h4f}, {1'b0, wr_q[1]});
      chk("set top address", {1'b0, 7'h7f, 8'h01}, {1'b0, wr_q[2]});
      chk("clear address 0", {1'b0, 7'h00, 8'hfe}, {1'b0, wr_q[3]});
    end
    chk("no skip", 16'h0000, 16'(skips));
  endtask : t_clear_set

  task automatic t_skip();
    hold();
    mem[0] = enc(2'h2, 3'h1, 7'h10);
    mem[1] = enc(2'h1, 3'h2, 7'h20);
    mem[2] = enc(2'h1, 3'h5, 7'h21);
    mem[3] = enc(2'h2, 3'h7, 7'h11);
    mem[4] = enc(2'h0, 3'h7, 7'h11);
    file[16] = 8'hfd;
    file[17] = 8'h80;
    go(10);
    chk("skip pulses", 16'h0001, 16'(skips));
    chk("nop slots", 16'h0001, 16'(nops));
    chk("write count", 16'h0002, 16'(wr_q.size()));
    if (wr_q.size() == 2) begin
      chk("word after nop", {1'b0, 7'h21, 8'h20}, {1'b0, wr_q[0]});
      chk("word after no skip", {1'b0, 7'h11, 8'h00}, {1'b0, wr_q[1]});
    end
  endtask : t_skip

  task automatic t_other();
    hold();
    mem[0] = enc(2'h3, 3'h1, 7'h10);
    mem[1] = 14'h2000;
    mem[9] = enc(2'h3, 3'h2, 7'h55);
    go(10);
    chk("fetch address", 16'h000a, {3'h0, prog_addr});
    chk("read address", 16'h0055, {9'h000, fr_raddr});
    chk("executing word", {2'h0, mem[9]}, {2'h0, other_word});
    chk("other valid", 16'h0001, {15'h0000, other_valid});
    chk("other count", 16'h0009, 16'(oth_q.size()));
    if (oth_q.size() > 1) begin
      chk("skip if set handed on", {2'h0, mem[0]}, {2'h0, oth_q[0]});
      chk("other class handed on", 16'h2000, {2'h0, oth_q[1]});
    end
    chk("no write", 16'h0000, 16'(wr_q.size() + skips));
  endtask : t_other

  task automatic wrap_up();
    if (miscompares == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  initial begin
    t_clear_set();
    t_skip();
    t_other();
    wrap_up();
  end

  initial begin
    #400000;
    miscompares++;
    wrap_up();
  end
endmodule : bit_oriented_file_ops_tb
